//--- io_ports_defs.svh
// Register offsets, reset values and field positions of the parallel port block
`ifndef IO_PORTS_DEFS_SVH
`define IO_PORTS_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_PORT_ZERO_OUTPUT_LATCH 6'h00
`define IDX_PORT_ONE_OUTPUT_LATCH 6'h01
`define IDX_PORT_TWO_OUTPUT_LATCH 6'h02
`define IDX_PORT_ZERO_OUTPUT_TYPE 6'h08
`define IDX_PORT_ONE_DIRECTION 6'h09
`define IDX_PORT_ZERO_PIN_LEVEL 6'h0b
`define IDX_PORT_TWO_PIN_LEVEL 6'h0c
`define IDX_PORT_MODE_CONTROL 6'h2d

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_PORT_ZERO_OUTPUT_LATCH 8'hff
`define RST_PORT_ZERO_OUTPUT_TYPE 8'h00
`define RST_PORT_ONE_OUTPUT_LATCH 8'h00
`define RST_PORT_ONE_DIRECTION 8'h00
`define RST_PORT_TWO_OUTPUT_LATCH 3'h7
`define RST_PORT_MODE_CONTROL 1'h0

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define POS_DUAL_CLOCK_MODE 0
`define POS_STOP_RELEASE_BIT 0
`define POS_CRYSTAL_IN_BIT 1
`define POS_CRYSTAL_OUT_BIT 2

`endif

//--- io_ports_pkg.sv
// Types shared by the parallel port block
`default_nettype none

package io_ports_pkg;

    // Bus access sequence, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_FIRST = 4'b0010,
        ST_SECOND = 4'b0100,
        ST_ANSWER = 4'b1000
    } access_state_t;

    typedef logic [7:0] port_byte_t;

endpackage

`default_nettype wire

//--- pin_sync.sv
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stage_one <= '0;
            sync_out <= '0;
        end else begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end

endmodule

`default_nettype wire

//--- pin_driver.sv
// Registered driver for one port pin, push-pull or sink open-drain
`timescale 1ns/100ps
`default_nettype none

module pin_driver (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic latch_bit,
    input wire logic periph_bit,
    input wire logic push_pull,
    input wire logic drive_allow,
    input wire logic release_pin,
    output logic pin_out,
    output logic pin_oe
);

    logic eff_bit;

    // Peripheral can only pull low while the latch holds one
    assign eff_bit = latch_bit & periph_bit;

    // Open-drain sinks only on zero; release wins over everything
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
        end else if (release_pin || !drive_allow) begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
        end else if (push_pull) begin
            pin_out <= eff_bit;
            pin_oe <= 1'b1;
        end else begin
            pin_out <= 1'b0;
            pin_oe <= ~eff_bit;
        end
    end

endmodule

`default_nettype wire

//--- io_ports_top.sv
// Parallel ports zero to two with a classic Wishbone register slave
//
// Contract
// [R01] Pin levels are sampled in the first state
// [R02] Output latches change in the second state
// [R03] Outputs latched, inputs read live pin level
// [R04] Outside source holds input until read
// [R05] Reset: port zero latch ones, type zeros
// [R06] Type zero open-drain, type one push-pull
// [R07] Inputs: set latch one, then type zero
// [R08] Port zero latch and pin register separate
// [R09] Peripheral output needs latch held at one
// [R10] Port one direction: zero in, one out
// [R11] Reset: port one direction and latch zero
// [R12] Port one read mixes latch and pin
// [R13] Read-modify-write copies input pins into latch
// [R14] Timer output: latch one before direction
// [R15] Port two three bits, latch resets ones
// [R16] Port two inputs need latch one
// [R17] Dual-clock mode gives bits one, two to crystal
// [R18] Port two pin register, upper bits undefined
// [R19] Bit zero falling edge flags external interrupt
// [R20] Stop mode floats port two bit zero
// [R21] Open-drain sinks only on zero value
//
// Local design decision: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none

`include "io_ports_defs.svh"

module io_ports_top
    import io_ports_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Port zero pins
    input wire logic [7:0] port_zero_in,
    output logic [7:0] port_zero_out,
    output logic [7:0] port_zero_oe,
    // Port one pins
    input wire logic [7:0] port_one_in,
    output logic [7:0] port_one_out,
    output logic [7:0] port_one_oe,
    // Port two pins
    input wire logic [2:0] port_two_in,
    output logic [2:0] port_two_out,
    output logic [2:0] port_two_oe,
    // Peripheral output functions, idle high
    input wire logic [7:0] periph_zero_out,
    input wire logic [7:0] periph_one_out,
    // System state
    input wire logic stop_mode_active,
    // Synchronised pin levels towards the peripherals, the registered dual-clock mode copy and the stop-release fall flag
    output logic [7:0] port_zero_level,
    output logic [7:0] port_one_level,
    output logic [2:0] port_two_level,
    output logic dual_clock_mode,
    output logic stop_release_fall
);

    // ------------------------------------------------------------------------
    // Registers and local signals
    // ------------------------------------------------------------------------
    access_state_t state;
    access_state_t next_state;
    port_byte_t port_zero_output_latch;
    port_byte_t port_zero_output_type;
    port_byte_t port_one_output_latch;
    port_byte_t port_one_direction;
    logic [2:0] port_two_output_latch;
    logic port_mode_control;
    logic stop_release_prev;
    logic [5:0] reg_index;
    logic req;
    logic write_now;
    logic lane_zero;
    logic [7:0] read_byte;
    logic [7:0] drive_push_pull_zero;
    logic [2:0] drive_allow_two;
    logic [2:0] release_two;

    assign reg_index = wb_adr_i[7:2];
    assign req = wb_cyc_i & wb_stb_i;
    assign lane_zero = wb_sel_i[0];
    // Latches change only at the end of the second state
    assign write_now = (state == ST_SECOND) & req & wb_we_i & lane_zero; // see [R02]

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    // Pins come from outside the clock domain
    pin_sync #(.WIDTH(8)) sync_zero (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(port_zero_in),
        .sync_out(port_zero_level)
    );

    pin_sync #(.WIDTH(8)) sync_one (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(port_one_in),
        .sync_out(port_one_level)
    );

    pin_sync #(.WIDTH(3)) sync_two (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(port_two_in),
        .sync_out(port_two_level)
    );

    // ------------------------------------------------------------------------
    // Access sequence
    // ------------------------------------------------------------------------
    // Idle, first state (sample), second state (write), answer
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (req) begin
                    next_state = ST_FIRST;
                end
            end
            ST_FIRST: begin
                next_state = ST_SECOND;
            end
            ST_SECOND: begin
                next_state = ST_ANSWER;
            end
            ST_ANSWER: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Ack rises as the latch write lands, drops one cycle later
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= (state == ST_SECOND) & req;
        end
    end

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    // Unmapped indexes read zero, narrow registers pad with zero
    always_comb begin
        read_byte = 8'h00;
        if (reg_index == `IDX_PORT_ZERO_OUTPUT_LATCH) begin
            read_byte = port_zero_output_latch; // see [R08]
        end else if (reg_index == `IDX_PORT_ONE_OUTPUT_LATCH) begin
            // Input bits show the pin, so a read-modify-write
            // copies pins into their latches
            read_byte = (port_one_direction & port_one_output_latch)
                | (~port_one_direction & port_one_level); // see [R12] see [R13]
        end else if (reg_index == `IDX_PORT_TWO_OUTPUT_LATCH) begin
            read_byte = {5'h00, port_two_output_latch}; // see [R18]
        end else if (reg_index == `IDX_PORT_ZERO_OUTPUT_TYPE) begin
            read_byte = port_zero_output_type;
        end else if (reg_index == `IDX_PORT_ONE_DIRECTION) begin
            read_byte = port_one_direction;
        end else if (reg_index == `IDX_PORT_ZERO_PIN_LEVEL) begin
            read_byte = port_zero_level; // see [R03] see [R08]
        end else if (reg_index == `IDX_PORT_TWO_PIN_LEVEL) begin
            // Upper bits undefined by the port; returned as zero
            read_byte = {5'h00, port_two_level}; // see [R18]
        end else if (reg_index == `IDX_PORT_MODE_CONTROL) begin
            read_byte = {7'h00, port_mode_control};
        end
    end

    // Pin level captured at the end of the first state
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if ((state == ST_FIRST) && req && !wb_we_i) begin
            wb_dat_o <= {24'h00_0000, read_byte}; // see [R01] see [R03]
        end else if (state == ST_IDLE) begin
            wb_dat_o <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------------
    // Port zero registers
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            port_zero_output_latch <= `RST_PORT_ZERO_OUTPUT_LATCH; // see [R05]
        end else if (write_now && reg_index == `IDX_PORT_ZERO_OUTPUT_LATCH) begin
            port_zero_output_latch <= wb_dat_i[7:0]; // see [R03]
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            port_zero_output_type <= `RST_PORT_ZERO_OUTPUT_TYPE; // see [R05]
        end else if (write_now && reg_index == `IDX_PORT_ZERO_OUTPUT_TYPE) begin
            port_zero_output_type <= wb_dat_i[7:0];
        end
    end

    // ------------------------------------------------------------------------
    // Port one registers
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            port_one_output_latch <= `RST_PORT_ONE_OUTPUT_LATCH; // see [R11]
        end else if (write_now && reg_index == `IDX_PORT_ONE_OUTPUT_LATCH) begin
            // Whole byte is written, input bits included
            port_one_output_latch <= wb_dat_i[7:0]; // see [R13]
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            port_one_direction <= `RST_PORT_ONE_DIRECTION; // see [R11]
        end else if (write_now && reg_index == `IDX_PORT_ONE_DIRECTION) begin
            port_one_direction <= wb_dat_i[7:0]; // see [R10]
        end
    end

    // ------------------------------------------------------------------------
    // Port two and mode registers
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            port_two_output_latch <= `RST_PORT_TWO_OUTPUT_LATCH; // see [R15]
        end else if (write_now && reg_index == `IDX_PORT_TWO_OUTPUT_LATCH) begin
            port_two_output_latch <= wb_dat_i[2:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            port_mode_control <= `RST_PORT_MODE_CONTROL;
        end else if (write_now && reg_index == `IDX_PORT_MODE_CONTROL) begin
            port_mode_control <= wb_dat_i[`POS_DUAL_CLOCK_MODE];
        end
    end

    // Registered copy for the clock generator
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dual_clock_mode <= 1'b0;
        end else begin
            dual_clock_mode <= port_mode_control; // see [R17]
        end
    end

    // ------------------------------------------------------------------------
    // Stop-release edge
    // ------------------------------------------------------------------------
    // Any falling edge counts, even one the port drives itself,
    // which is why this bit is best left as an input
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            // Low like the synchroniser's reset, so no false fall after reset
            stop_release_prev <= 1'b0;
            stop_release_fall <= 1'b0;
        end else begin
            stop_release_prev <= port_two_level[`POS_STOP_RELEASE_BIT];
            stop_release_fall <= stop_release_prev
                & ~port_two_level[`POS_STOP_RELEASE_BIT]; // see [R19]
        end
    end

    // ------------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------------
    assign drive_push_pull_zero = port_zero_output_type; // see [R06]

    // Crystal pins in dual-clock mode and the stop-release pin in stop mode are taken from the port
    always_comb begin
        drive_allow_two = 3'h7;
        release_two = 3'h0;
        drive_allow_two[`POS_CRYSTAL_IN_BIT] = ~port_mode_control; // see [R17]
        drive_allow_two[`POS_CRYSTAL_OUT_BIT] = ~port_mode_control; // see [R17]
        release_two[`POS_STOP_RELEASE_BIT] = stop_mode_active; // see [R20]
    end

    for (genvar i = 0; i < 8; i++) begin : g_zero
        // Open-drain sinks only on zero; periph output gated by latch
        pin_driver drv (
            .core_clk(core_clk),
            .rst(rst),
            .latch_bit(port_zero_output_latch[i]),
            .periph_bit(periph_zero_out[i]),
            .push_pull(drive_push_pull_zero[i]),
            .drive_allow(1'b1),
            .release_pin(1'b0),
            .pin_out(port_zero_out[i]),
            .pin_oe(port_zero_oe[i])
        ); // see [R06] see [R21]
    end

    for (genvar i = 0; i < 8; i++) begin : g_one
        // Direction bit enables a push-pull driver
        pin_driver drv (
            .core_clk(core_clk),
            .rst(rst),
            .latch_bit(port_one_output_latch[i]),
            .periph_bit(periph_one_out[i]),
            .push_pull(1'b1),
            .drive_allow(port_one_direction[i]),
            .release_pin(1'b0),
            .pin_out(port_one_out[i]),
            .pin_oe(port_one_oe[i])
        ); // see [R10]
    end

    for (genvar i = 0; i < 3; i++) begin : g_two
        // Sink open-drain, so a latch of one leaves the pin free
        pin_driver drv (
            .core_clk(core_clk),
            .rst(rst),
            .latch_bit(port_two_output_latch[i]),
            .periph_bit(1'b1),
            .push_pull(1'b0),
            .drive_allow(drive_allow_two[i]),
            .release_pin(release_two[i]),
            .pin_out(port_two_out[i]),
            .pin_oe(port_two_oe[i])
        ); // see [R20]
    end

endmodule

`default_nettype wire

//--- pin_board_model.sv
// Pin board model: pull-ups on ports zero and two, an outside driver on port one
`timescale 1ns/100ps
`default_nettype none

module pin_board_model (
    input wire logic [7:0] port_zero_out,
    input wire logic [7:0] port_zero_oe,
    input wire logic [7:0] port_one_out,
    input wire logic [7:0] port_one_oe,
    input wire logic [2:0] port_two_out,
    input wire logic [2:0] port_two_oe,
    input wire logic [7:0] ext_one,
    output logic [7:0] port_zero_in,
    output logic [7:0] port_one_in,
    output logic [2:0] port_two_in
);
    // ------------
    // Wire levels
    // ------------
    // Released sink pins float high through their pull-ups
    assign port_zero_in = (port_zero_oe & port_zero_out) | ~port_zero_oe;
    assign port_two_in = (port_two_oe & port_two_out) | ~port_two_oe;
    // Outside source ext_one sets the level of every port one pin that the port does not drive
    assign port_one_in = (port_one_oe & port_one_out) | (~port_one_oe & ext_one);
endmodule

`default_nettype wire

//--- io_ports_chk.sv
// Concurrent checks on the port block bus and pins
`timescale 1ns/100ps
`default_nettype none

`include "io_ports_defs.svh"

module io_ports_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [7:0] port_zero_in,
    input wire logic [7:0] port_zero_out,
    input wire logic [7:0] port_zero_oe,
    input wire logic [7:0] port_one_in,
    input wire logic [7:0] port_one_out,
    input wire logic [7:0] port_one_oe,
    input wire logic [2:0] port_two_out,
    input wire logic [2:0] port_two_oe,
    input wire logic stop_mode_active,
    input wire logic [7:0] port_zero_level,
    input wire logic [7:0] port_one_level,
    input wire logic [2:0] port_two_level,
    input wire logic dual_clock_mode,
    input wire logic stop_release_fall
);
    // ---------
    // Settling
    // ---------
    logic [1:0] settle;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // Synchronisers show reset values for two edges after release
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            settle <= 2'h0;
        end else if (settle != 2'h3) begin
            settle <= settle + 2'h1;
        end
    end

    // -----------
    // Assertions
    // -----------
    // Request seen at the taking edge, ack sampled high three edges later
    a_ack_latency: assert property (
        $rose(wb_cyc_i && wb_stb_i) |-> !wb_ack_o [*3] ##1 wb_ack_o)
        else $error("ack not three cycles after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_in_cycle: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
        else $error("ack outside a request");
    a_two_upper: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h0c |-> wb_dat_o[7:3] == 5'h00)
        else $error("port two read has upper bits set");
    a_drive_qual: assert property (
        ((port_zero_out & ~port_zero_oe) | (port_one_out & ~port_one_oe)) == 8'h00)
        else $error("output high while not driven");
    a_two_sink: assert property (port_two_out == 3'h0)
        else $error("port two sources current");
    a_stop_float: assert property (stop_mode_active |=> !port_two_oe[0])
        else $error("stop release pin driven in stop");
    a_dual_float: assert property (
        dual_clock_mode && $past(dual_clock_mode) |-> port_two_oe[2:1] == 2'h0)
        else $error("crystal pins driven");
    a_level_track: assert property (
        settle == 2'h3 |-> port_zero_level == $past(port_zero_in, 2)
        && port_one_level == $past(port_one_in, 2))
        else $error("pin level not two edges behind pin");
    a_fall_flag: assert property (
        settle == 2'h3 && $fell(port_two_level[0]) |-> ##[0:1] stop_release_fall)
        else $error("falling edge not flagged");
    a_fall_pulse: assert property (
        stop_release_fall |-> !port_two_level[0] ##1 !stop_release_fall)
        else $error("fall flag without low level");

    // Main scenarios reached
    c_write: cover property (wb_ack_o && wb_we_i);
    c_fall: cover property (stop_release_fall);
    c_dual: cover property (dual_clock_mode && !stop_mode_active);
endmodule

bind io_ports_top io_ports_chk u_chk (.core_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_o, .wb_ack_o, .port_zero_in, .port_zero_out, .port_zero_oe, .port_one_in, .port_one_out,
    .port_one_oe, .port_two_out, .port_two_oe, .stop_mode_active, .port_zero_level, .port_one_level,
    .port_two_level, .dual_clock_mode, .stop_release_fall);

`default_nettype wire

//--- parallel_io_ports_zero_to_two_bench.sv
// Self-checking bench for the parallel port block
`timescale 1ns/100ps
`default_nettype none

`define CHECK_EQ(got, exp) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
    $display("ERROR %0t: got %h expected %h", $time, got, exp); end end

module parallel_io_ports_zero_to_two_bench import io_ports_pkg::*;;
    logic core_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [7:0] port_zero_in, port_zero_out, port_zero_oe, port_one_in, port_one_out, port_one_oe;
    logic [7:0] periph_zero_out, periph_one_out, port_zero_level, port_one_level, ext_one;
    logic [2:0] port_two_in, port_two_out, port_two_oe, port_two_level;
    logic stop_mode_active, dual_clock_mode, stop_release_fall;
    int n_errors, check_count, cycles, falls;
    port_byte_t rd;

    io_ports_top u_dut (.core_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .port_zero_in, .port_zero_out, .port_zero_oe, .port_one_in,
        .port_one_out, .port_one_oe, .port_two_in, .port_two_out, .port_two_oe, .periph_zero_out,
        .periph_one_out, .stop_mode_active, .port_zero_level, .port_one_level, .port_two_level,
        .dual_clock_mode, .stop_release_fall);
    pin_board_model u_pins (.port_zero_out, .port_zero_oe, .port_one_out, .port_one_oe,
        .port_two_out, .port_two_oe, .ext_one, .port_zero_in, .port_one_in, .port_two_in);

    // ------------------
    // Clock and watchdog
    // ------------------
    initial begin
        core_clk = 1'h0;
        forever #25 core_clk = ~core_clk;
    end

    // A hang counts as a mismatch and closes the run
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (stop_release_fall === 1'h1) falls <= falls + 1;
        if (cycles == 3000) begin
            n_errors++;
            print_verdict();
        end
    end

    // ------------
    // Bus tasks
    // ------------
    // Classic cycle held until ack is sampled, then one idle cycle
    task automatic bus(input logic we, input logic [5:0] idx, input port_byte_t wd, input logic s0);
        int n;
        n = 0;
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'h0};
        wb_sel_i <= {3'h0, s0};
        wb_dat_i <= {24'h00_0000, wd};
        @(posedge core_clk);
        while (wb_ack_o !== 1'h1 && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 50) n_errors++;
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [5:0] idx, input port_byte_t wd);
        bus(1'h1, idx, wd, 1'h1);
    endtask

    task automatic rchk(input logic [5:0] idx, input port_byte_t exp);
        bus(1'h0, idx, 8'h00, 1'h1);
        `CHECK_EQ(rd, exp)
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic print_verdict();
        if (n_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ----------
    // Sequence
    // ----------
    initial begin
        {rst, wb_cyc_i, wb_stb_i, wb_we_i, stop_mode_active} = 5'h10;
        {wb_adr_i, wb_sel_i, wb_dat_i} = 44'h000_0000_0000;
        {periph_zero_out, periph_one_out, ext_one} = 24'hff_ff3c;
        {n_errors, check_count} = 64'h0;
        tick(8);
        rst <= 1'h0;
        tick(1);
        rchk(6'h00, 8'hff);
        rchk(6'h08, 8'h00);
        rchk(6'h09, 8'h00);
        rchk(6'h01, 8'h3c);
        rchk(6'h02, 8'h07);
        `CHECK_EQ({port_zero_oe, port_one_oe, port_two_oe}, 19'h0_0000)
        // Latch first, then output type, as inputs require
        wr(6'h00, 8'h5a);
        wr(6'h08, 8'h0f);
        `CHECK_EQ({port_zero_oe, port_zero_out}, 16'haf0a)
        tick(3);
        rchk(6'h0b, 8'h5a);
        periph_zero_out <= 8'hfd;
        tick(2);
        `CHECK_EQ(port_zero_out, 8'h08)
        tick(3);
        rchk(6'h0b, 8'h58);
        periph_zero_out <= 8'hff;
        // Refused writes: lane zero off, unmapped, read-only
        bus(1'h1, 6'h00, 8'h00, 1'h0);
        bus(1'h1, 6'h3f, 8'hff, 1'h1);
        bus(1'h1, 6'h0b, 8'h00, 1'h1);
        rchk(6'h00, 8'h5a);
        rchk(6'h3f, 8'h00);
        rchk(6'h0b, 8'h5a);
        // Port one: latch before direction for timer outputs
        wr(6'h01, 8'h55);
        wr(6'h09, 8'hf0);
        `CHECK_EQ({port_one_oe, port_one_out}, 16'hf050)
        rchk(6'h01, 8'h5c);
        wr(6'h01, rd | 8'h01);
        wr(6'h09, 8'hff);
        `CHECK_EQ(port_one_out, 8'h5d)
        periph_one_out <= 8'hbf;
        tick(2);
        `CHECK_EQ(port_one_out, 8'h1d)
        periph_one_out <= 8'hff;
        // Port two: bit zero driven low, then stop mode
        wr(6'h02, 8'h02);
        `CHECK_EQ(port_two_oe, 3'h5)
        tick(3);
        rchk(6'h0c, 8'h02);
        // Only the driven fall counts; reset must not leave a false one
        `CHECK_EQ(falls, 1)
        stop_mode_active <= 1'h1;
        tick(2);
        `CHECK_EQ(port_two_oe, 3'h4)
        tick(3);
        rchk(6'h0c, 8'h03);
        stop_mode_active <= 1'h0;
        wr(6'h2d, 8'h01);
        `CHECK_EQ({dual_clock_mode, port_two_oe}, 4'h9)
        wr(6'h2d, 8'h00);
        `CHECK_EQ({dual_clock_mode, port_two_oe}, 4'h5)
        print_verdict();
    end
endmodule

`default_nettype wire
